/* pkg/pfp_consts.svh */
// constants of the pin function and pwm configuration block
// assumes a 50 MHz system clock; included by the package file only, the modules do not include it
`ifndef PFP_CONSTS_SVH
`define PFP_CONSTS_SVH

// pin selector codes
`define PFP_SEL_DISABLED  3'h0
`define PFP_SEL_FUNC      3'h1
`define PFP_SEL_PWM       3'h2
`define PFP_SEL_INPUT     3'h3
`define PFP_SEL_OUT_LOW   3'h4
`define PFP_SEL_OUT_HIGH  3'h5

// reset values
`define PFP_RST_SEL_SLEEP_RQ  3'h1
`define PFP_RST_SEL_SLEEP_IND 3'h1
`define PFP_RST_SEL_LINE10    3'h1
`define PFP_RST_SEL_LINE11    3'h0
`define PFP_RST_SEL_LINE12    3'h0
`define PFP_RST_PULL          20'h0ffff
`define PFP_RST_DUTY          10'h000
`define PFP_RST_HOLD          8'h28
`define PFP_HOLD_FOREVER      8'hff
`define PFP_TH_MASK_HI        4'h0

// command register select codes
`define PFP_REG_SEL_SLEEP_RQ  4'h0
`define PFP_REG_SEL_SLEEP_IND 4'h1
`define PFP_REG_SEL_LINE10    4'h2
`define PFP_REG_SEL_LINE11    4'h3
`define PFP_REG_SEL_LINE12    4'h4
`define PFP_REG_PULL_EN       4'h5
`define PFP_REG_PULL_DIR      4'h6
`define PFP_REG_LEVEL         4'h7
`define PFP_REG_DUTY0         4'h8
`define PFP_REG_DUTY1         4'h9
`define PFP_REG_HOLD          4'ha
`define PFP_REG_STATUS        4'hb

// timing
`define PFP_CLK_PERIOD_NS     20
`define PFP_PWM_PERIOD_NS     64000
`define PFP_PWM_PERIOD_CYCLES ((`PFP_PWM_PERIOD_NS) / (`PFP_CLK_PERIOD_NS))
`define PFP_PWM_STEPS         13'h03ff
`define PFP_PWM_LAST_STEP     10'h3fe
`define PFP_HOLD_UNIT_NS      100000000
`define PFP_HOLD_UNIT_CYCLES  ((`PFP_HOLD_UNIT_NS) / (`PFP_CLK_PERIOD_NS))

`endif

/* pkg/pfp_pkg.sv */
// types of the pin function and pwm configuration block
// assumes pfp_consts.svh is on the include path
`include "pfp_consts.svh"
package pfp_pkg;
  typedef logic [2:0] pfp_sel_t;
  typedef logic [9:0] pfp_duty_t;
  typedef enum logic [3:0] {
    PFP_REG_SEL_SLEEP_RQ  = `PFP_REG_SEL_SLEEP_RQ,
    PFP_REG_SEL_SLEEP_IND = `PFP_REG_SEL_SLEEP_IND,
    PFP_REG_SEL_LINE10    = `PFP_REG_SEL_LINE10,
    PFP_REG_SEL_LINE11    = `PFP_REG_SEL_LINE11,
    PFP_REG_SEL_LINE12    = `PFP_REG_SEL_LINE12,
    PFP_REG_PULL_EN       = `PFP_REG_PULL_EN,
    PFP_REG_PULL_DIR      = `PFP_REG_PULL_DIR,
    PFP_REG_LEVEL         = `PFP_REG_LEVEL,
    PFP_REG_DUTY0         = `PFP_REG_DUTY0,
    PFP_REG_DUTY1         = `PFP_REG_DUTY1,
    PFP_REG_HOLD          = `PFP_REG_HOLD,
    PFP_REG_STATUS        = `PFP_REG_STATUS
  } pfp_reg_t;
endpackage

/* design/pfp_pwm.sv */
// one pwm channel: compares a shared step count against its duty
// assumes the step count and period start come from one shared divider
`timescale 1ns/1ps
module pfp_pwm
  import pfp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset,
  input  wire logic      period_start,
  input  wire logic [9:0] step,
  input  wire pfp_duty_t duty,
  output logic           pwm_out
);
  pfp_duty_t duty_live;

  // duty taken only at a period edge, so no runt pulses on a change
  always_ff @(posedge clk) begin
    if (reset) begin
      duty_live <= `PFP_RST_DUTY;
    end else if (period_start) begin
      duty_live <= duty;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (step < duty_live);
    end
  end

  AST_PWM_FULL: assert property (@(posedge clk) disable iff (reset)
    (duty_live == 10'h3ff) |=> pwm_out)
    else $error("full duty channel went low");
endmodule

/* design/pfp_hold_timer.sv */
// hold timer of the signal strength pwm output, in tenths of a second
// assumes start is a one-cycle pulse per received packet
`timescale 1ns/1ps
module pfp_hold_timer
  import pfp_pkg::*;
#(
  parameter int TENTH_CYCLES = `PFP_HOLD_UNIT_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [7:0] hold_value,
  output logic            active
);
  logic [22:0] div;
  logic [7:0]  count;
  logic        tick;

  assign tick = (div == 23'(TENTH_CYCLES - 1));

  // reload per packet, count down
  // divider restarts on each packet so the hold is exact to a cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      div   <= 23'h0;
      count <= 8'h00;
    end else if (start) begin
      div   <= 23'h0;
      count <= hold_value;
    end else if (count != 8'h00) begin
      div <= tick ? 23'h0 : div + 23'h1;
      if (tick) begin
        count <= count - 8'h01;
      end
    end
  end

  assign active = (hold_value == `PFP_HOLD_FOREVER) || (count != 8'h00);

  AST_HOLD_EXPIRE: assert property (@(posedge clk) disable iff (reset)
    (count == 8'h01 && tick && !start
     && hold_value == $past(hold_value)
     && hold_value != `PFP_HOLD_FOREVER) |=> !active)
    else $error("hold timer did not expire");

  COV_HOLD_EXPIRE: cover property (@(posedge clk) disable iff (reset)
    active ##1 !active);
endmodule

/* design/pfp_pin_config.sv */
// pin function, pull resistor and pwm configuration for five i/o lines
// assumes command writes come from the host command layer on clk, and
// that pad inputs and the variant strap arrive from outside the domain
`timescale 1ns/1ps
module pfp_pin_config
  import pfp_pkg::*;
#(
  parameter int HOLD_UNIT_CYCLES = `PFP_HOLD_UNIT_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd_write,
  input  wire pfp_reg_t    cmd_reg,
  input  wire logic [19:0] cmd_data,
  input  wire logic        cmd_apply,
  output logic             cmd_reject,
  input  wire pfp_reg_t    rd_reg,
  output logic [19:0]      rd_data,
  input  wire logic        variant_through_hole,
  input  wire logic        asleep,
  output logic             sleep_request_input,
  input  wire logic        rx_packet,
  input  wire logic [6:0]  rx_power_mag,
  input  wire logic        lp_source_valid,
  input  wire logic        lp_sample_valid,
  input  wire pfp_duty_t   lp_sample_data,
  input  wire logic        spi_peripheral_dout,
  input  wire logic [4:0]  line_in,
  output logic [4:0]       line_out,
  output logic [4:0]       line_oe,
  output logic [19:0]      dio_pull_enable,
  output logic [19:0]      dio_pull_up,
  output logic [7:0]       level_map
);
  // mask bit to dio line number
  localparam int unsigned DIO_OF_BIT [20] = '{4, 3, 2, 1, 0, 6, 8, 14, 5,
    9, 12, 10, 11, 7, 13, 15, 16, 17, 18, 19};
  localparam int OWN_BASE = 8;           // our lines are dio 8 to 12

  pfp_sel_t    sleep_request_pin_select;
  pfp_sel_t    sleep_indicator_pin_select;
  pfp_sel_t    line10_pin_select;
  pfp_sel_t    line11_pin_select;
  pfp_sel_t    line12_pin_select;
  logic [19:0] pull_enable_mask;
  logic [19:0] pull_polarity_mask;
  logic [7:0]  output_level_map;
  pfp_duty_t   pwm_ch0_duty;
  pfp_duty_t   pwm_ch1_duty;
  logic [7:0]  signal_strength_hold_timer;
  pfp_sel_t    sel [5];
  pfp_duty_t   duty_a;
  pfp_duty_t   duty_b;
  pfp_duty_t   signal_strength_duty;
  logic [4:0]  line_level;
  logic [4:0]  line_meta;
  logic [4:0]  line_sync;
  logic        th_meta;
  logic        th_sync;
  logic        write_ok;
  logic [2:0]  wcode;
  logic        code_ok;
  logic [11:0] acc;
  logic [12:0] acc_sum;
  logic        step_en;
  logic [9:0]  step;
  logic        period_start;
  logic        pwm_channel_a;
  logic        pwm_channel_b;
  logic        signal_strength_pwm;
  logic        hold_active;
  logic        pass_a;
  logic        pass_b;
  logic [4:0]  next_out;
  logic [4:0]  next_oe;
  logic [19:0] next_pull_en;
  logic [19:0] next_pull_up;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // pads and strap cross into the clock domain through two flops
  always_ff @(posedge clk) begin
    if (reset) begin
      line_meta <= 5'h00;
      line_sync <= 5'h00;
      th_meta   <= 1'b0;
      th_sync   <= 1'b0;
    end else begin
      line_meta <= line_in;
      line_sync <= line_meta;
      th_meta   <= variant_through_hole;
      th_sync   <= th_meta;
    end
  end

  assign sel[0] = sleep_request_pin_select;
  assign sel[1] = sleep_indicator_pin_select;
  assign sel[2] = line10_pin_select;
  assign sel[3] = line11_pin_select;
  assign sel[4] = line12_pin_select;
  assign wcode   = cmd_data[2:0];
  assign code_ok = (cmd_data[19:3] == 17'h0);

  always_comb begin
    write_ok = 1'b0;
    case (cmd_reg)
      PFP_REG_SEL_SLEEP_RQ, PFP_REG_SEL_SLEEP_IND:
        write_ok = code_ok && wcode <= `PFP_SEL_OUT_HIGH
                   && wcode != `PFP_SEL_PWM;
      PFP_REG_SEL_LINE10:
        write_ok = code_ok && wcode <= `PFP_SEL_OUT_HIGH;
      PFP_REG_SEL_LINE11:
        write_ok = code_ok && wcode <= `PFP_SEL_OUT_HIGH
                   && wcode != `PFP_SEL_FUNC;
      PFP_REG_SEL_LINE12:
        write_ok = code_ok && wcode <= `PFP_SEL_OUT_HIGH
                   && wcode != `PFP_SEL_PWM
                   && (wcode != `PFP_SEL_FUNC || th_sync);
      PFP_REG_PULL_EN, PFP_REG_PULL_DIR:
        write_ok = !th_sync || cmd_data[19:16] == `PFP_TH_MASK_HI;
      PFP_REG_LEVEL, PFP_REG_HOLD:
        write_ok = (cmd_data[19:8] == 12'h0);
      PFP_REG_DUTY0, PFP_REG_DUTY1:
        write_ok = (cmd_data[19:10] == 10'h0);
      default:
        write_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= cmd_write && !write_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_request_pin_select   <= `PFP_RST_SEL_SLEEP_RQ;
      sleep_indicator_pin_select <= `PFP_RST_SEL_SLEEP_IND;
      line10_pin_select          <= `PFP_RST_SEL_LINE10;
      line11_pin_select          <= `PFP_RST_SEL_LINE11;
      line12_pin_select          <= `PFP_RST_SEL_LINE12;
    end else if (cmd_write && write_ok) begin
      case (cmd_reg)
        PFP_REG_SEL_SLEEP_RQ:  sleep_request_pin_select   <= wcode;
        PFP_REG_SEL_SLEEP_IND: sleep_indicator_pin_select <= wcode;
        PFP_REG_SEL_LINE10:    line10_pin_select          <= wcode;
        PFP_REG_SEL_LINE11:    line11_pin_select          <= wcode;
        PFP_REG_SEL_LINE12:    line12_pin_select          <= wcode;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pull_enable_mask   <= `PFP_RST_PULL;
      pull_polarity_mask <= `PFP_RST_PULL;
    end else if (cmd_write && write_ok) begin
      if (cmd_reg == PFP_REG_PULL_EN) begin
        pull_enable_mask <= cmd_data;
      end
      if (cmd_reg == PFP_REG_PULL_DIR) begin
        pull_polarity_mask <= cmd_data;
      end
    end
  end

  // level of each output line
  // a selector write of low or high seeds the level it then holds
  always_ff @(posedge clk) begin
    if (reset) begin
      output_level_map <= 8'h00;
      line_level       <= 5'h00;
    end else if (cmd_write && write_ok) begin
      if (cmd_reg == PFP_REG_LEVEL) begin
        output_level_map <= cmd_data[7:0];
        for (int i = 0; i < 5; i++) begin
          if (sel[i] == `PFP_SEL_OUT_LOW || sel[i] == `PFP_SEL_OUT_HIGH) begin
            line_level[i] <= cmd_data[i];
          end
        end
      end else if (cmd_reg <= PFP_REG_SEL_LINE12) begin
        line_level[cmd_reg[2:0]] <= (wcode == `PFP_SEL_OUT_HIGH);
      end
    end
  end
  assign level_map = output_level_map;

  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_ch0_duty               <= `PFP_RST_DUTY;
      pwm_ch1_duty               <= `PFP_RST_DUTY;
      signal_strength_hold_timer <= `PFP_RST_HOLD;
    end else begin
      if (cmd_write && write_ok) begin
        case (cmd_reg)
          PFP_REG_DUTY0: pwm_ch0_duty               <= cmd_data[9:0];
          PFP_REG_DUTY1: pwm_ch1_duty               <= cmd_data[9:0];
          PFP_REG_HOLD:  signal_strength_hold_timer <= cmd_data[7:0];
          default: ;
        endcase
      end
      // so a later apply does not revert it
      if (pass_a) begin
        pwm_ch0_duty <= lp_sample_data;
      end
      if (pass_b) begin
        pwm_ch1_duty <= lp_sample_data;
      end
    end
  end

  assign pass_a = lp_source_valid && lp_sample_valid
                  && line10_pin_select == `PFP_SEL_PWM;
  assign pass_b = lp_source_valid && lp_sample_valid
                  && line11_pin_select == `PFP_SEL_PWM;

  // duty takes effect on apply
  // a passed sample is newer than a staged value, so it wins a tie
  always_ff @(posedge clk) begin
    if (reset) begin
      duty_a <= `PFP_RST_DUTY;
      duty_b <= `PFP_RST_DUTY;
    end else begin
      if (pass_a) begin
        duty_a <= lp_sample_data;
      end else if (cmd_apply) begin
        duty_a <= pwm_ch0_duty;
      end
      if (pass_b) begin
        duty_b <= lp_sample_data;
      end else if (cmd_apply) begin
        duty_b <= pwm_ch1_duty;
      end
    end
  end

  // packet power sets duty
  // weaker packets (larger magnitude) give a shorter high time
  always_ff @(posedge clk) begin
    if (reset) begin
      signal_strength_duty <= `PFP_RST_DUTY;
    end else if (rx_packet) begin
      signal_strength_duty <= 10'h3ff - {rx_power_mag, 3'b000};
    end
  end

  // 1023 steps per 64 us
  // fractional accumulator spreads 1023 steps evenly over the period
  assign acc_sum = {1'b0, acc} + `PFP_PWM_STEPS;
  assign step_en = (acc_sum >= 13'(`PFP_PWM_PERIOD_CYCLES));
  assign period_start = step_en && (step == `PFP_PWM_LAST_STEP);
  always_ff @(posedge clk) begin
    if (reset) begin
      acc  <= 12'h000;
      step <= 10'h000;
    end else begin
      acc <= step_en ? 12'(acc_sum - 13'(`PFP_PWM_PERIOD_CYCLES))
                     : acc_sum[11:0];
      if (step_en) begin
        step <= period_start ? 10'h000 : step + 10'h001;
      end
    end
  end

  pfp_pwm u_pwm_a (
    .clk          (clk),
    .reset        (reset),
    .period_start (period_start),
    .step         (step),
    .duty         (duty_a),
    .pwm_out      (pwm_channel_a)
  );

  pfp_pwm u_pwm_b (
    .clk          (clk),
    .reset        (reset),
    .period_start (period_start),
    .step         (step),
    .duty         (duty_b),
    .pwm_out      (pwm_channel_b)
  );

  pfp_pwm u_pwm_strength (
    .clk          (clk),
    .reset        (reset),
    .period_start (period_start),
    .step         (step),
    .duty         (signal_strength_duty),
    .pwm_out      (signal_strength_pwm)
  );

  pfp_hold_timer #(
    .TENTH_CYCLES (HOLD_UNIT_CYCLES)
  ) u_hold (
    .clk        (clk),
    .reset      (reset),
    .start      (rx_packet),
    .hold_value (signal_strength_hold_timer),
    .active     (hold_active)
  );

  // drive of each line from its selector
  always_comb begin
    next_out = 5'h00;
    next_oe  = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (sel[i] == `PFP_SEL_OUT_LOW || sel[i] == `PFP_SEL_OUT_HIGH) begin
        next_oe[i]  = 1'b1;
        next_out[i] = line_level[i];
      end
    end
    if (sleep_indicator_pin_select == `PFP_SEL_FUNC) begin
      next_oe[1]  = 1'b1;
      next_out[1] = !asleep;
    end
    if (line10_pin_select == `PFP_SEL_FUNC) begin
      next_oe[2]  = 1'b1;
      next_out[2] = signal_strength_pwm && hold_active;
    end
    if (line10_pin_select == `PFP_SEL_PWM) begin
      next_oe[2]  = 1'b1;
      next_out[2] = pwm_channel_a;
    end
    if (line11_pin_select == `PFP_SEL_PWM) begin
      next_oe[3]  = 1'b1;
      next_out[3] = pwm_channel_b;
    end
    if (line12_pin_select == `PFP_SEL_FUNC) begin
      next_oe[4]  = 1'b1;
      next_out[4] = spi_peripheral_dout;
    end
  end

  always_comb begin
    next_pull_en = 20'h00000;
    next_pull_up = 20'h00000;
    for (int b = 0; b < 20; b++) begin
      next_pull_en[DIO_OF_BIT[b]] = pull_enable_mask[b];
      next_pull_up[DIO_OF_BIT[b]] = pull_polarity_mask[b];
    end
    for (int i = 0; i < 5; i++) begin
      if (sel[i] != `PFP_SEL_DISABLED && sel[i] != `PFP_SEL_INPUT) begin
        next_pull_en[OWN_BASE + i] = 1'b0;
        next_pull_up[OWN_BASE + i] = 1'b0;
      end
    end
  end

  // sleep request floats asleep
  // pad outputs registered so the pins never glitch on selector decode
  always_ff @(posedge clk) begin
    if (reset) begin
      line_out            <= 5'h00;
      line_oe             <= 5'h00;
      dio_pull_enable     <= `PFP_RST_PULL;
      dio_pull_up         <= `PFP_RST_PULL;
      sleep_request_input <= 1'b0;
    end else begin
      line_out        <= next_out;
      line_oe         <= next_oe;
      dio_pull_enable <= next_pull_en;
      dio_pull_up     <= next_pull_up;
      sleep_request_input <=
        (sleep_request_pin_select == `PFP_SEL_FUNC) && line_sync[0];
    end
  end

  // readback of settings and own state; write-only map reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= 20'h00000;
    end else begin
      case (rd_reg)
        PFP_REG_SEL_SLEEP_RQ:  rd_data <= 20'(sleep_request_pin_select);
        PFP_REG_SEL_SLEEP_IND: rd_data <= 20'(sleep_indicator_pin_select);
        PFP_REG_SEL_LINE10:    rd_data <= 20'(line10_pin_select);
        PFP_REG_SEL_LINE11:    rd_data <= 20'(line11_pin_select);
        PFP_REG_SEL_LINE12:    rd_data <= 20'(line12_pin_select);
        PFP_REG_PULL_EN:       rd_data <= pull_enable_mask;
        PFP_REG_PULL_DIR:      rd_data <= pull_polarity_mask;
        PFP_REG_DUTY0:         rd_data <= 20'(pwm_ch0_duty);
        PFP_REG_DUTY1:         rd_data <= 20'(pwm_ch1_duty);
        PFP_REG_HOLD:          rd_data <= 20'(signal_strength_hold_timer);
        PFP_REG_STATUS:        rd_data <= 20'({hold_active, th_sync,
                                               line_sync});
        default:               rd_data <= 20'h00000;
      endcase
    end
  end

  AST_SEL_SLEEP_RQ: assert property (
    sleep_request_pin_select != `PFP_SEL_PWM
    && sleep_request_pin_select <= `PFP_SEL_OUT_HIGH)
    else $error("sleep request selector holds illegal code");
  AST_SLEEP_FLOAT: assert property (
    (sleep_request_pin_select == `PFP_SEL_FUNC && asleep)
    |=> !line_oe[0] && !dio_pull_enable[OWN_BASE])
    else $error("sleep request line driven or pulled while asleep");
  AST_SEL_LINE11: assert property (
    line11_pin_select != `PFP_SEL_FUNC)
    else $error("line11 selector holds unsupported code");
  AST_SEL_LINE12: assert property (
    $rose(line12_pin_select == `PFP_SEL_FUNC) |-> $past(th_sync))
    else $error("line12 spi function on wrong variant");
  AST_REJECT: assert property (
    (cmd_write && cmd_reg == PFP_REG_SEL_LINE10 && cmd_data > 20'h5)
    |=> cmd_reject && $stable(line10_pin_select))
    else $error("illegal selector write not rejected");
  AST_PULL_GATE: assert property (
    (line10_pin_select == `PFP_SEL_PWM) |=> !dio_pull_enable[OWN_BASE + 2])
    else $error("pull applied to a function line");
  AST_PASS_A: assert property (
    pass_a |=> duty_a == $past(lp_sample_data))
    else $error("passed sample did not replace channel a duty");
  AST_LINE10_PWM: assert property (
    (line10_pin_select == `PFP_SEL_PWM) |=> line_oe[2]
    && line_out[2] == $past(pwm_channel_a))
    else $error("channel a not on line10");
  AST_HOLD_FOREVER: assert property (
    (signal_strength_hold_timer == `PFP_HOLD_FOREVER
     && line10_pin_select == `PFP_SEL_FUNC)
    |=> line_out[2] == $past(signal_strength_pwm))
    else $error("forever hold let the strength output drop");

  COV_APPLY: cover property (cmd_apply && pwm_ch0_duty != duty_a);
  COV_PASS: cover property (pass_a ##1 pass_b);
  COV_REJECT: cover property (cmd_reject);
endmodule

/* testbench/pfp_pads.sv */
// pad model: each line settles from drive, pull or a floating level
// assumes pad bit order dio 8..12 as the pin block presents it
`timescale 1ns/1ps
module pfp_pads (
  input  wire logic        clk,
  input  wire logic [4:0]  line_out,
  input  wire logic [4:0]  line_oe,
  input  wire logic [19:0] dio_pull_enable,
  input  wire logic [19:0] dio_pull_up,
  output logic      [4:0]  line_in
);
  logic flt = 1'b0;
  // a bare pad wanders, so a stale level never reads back as good
  always @(posedge clk) flt <= ~flt;
  always_comb
    for (int i = 0; i < 5; i++)
      line_in[i] = line_oe[i] ? line_out[i] :
        (dio_pull_enable[8+i] ? dio_pull_up[8+i] : flt);
endmodule

/* testbench/pin_function_pwm_config_bench.sv */
// bench of the pin function and pwm block with a pad model on its pins
// assumes the hold unit is shortened to 10 cycles
`timescale 1ns/1ps
module pin_function_pwm_config_bench;
  import pfp_pkg::*;
  logic clk = 0, reset = 1, cmd_write = 0, cmd_apply = 0, rx = 0, lp_v = 0;
  logic lp_src = 0, cmd_reject, spi = 0, asleep = 0, th = 0, sri;
  logic [7:0] lmap;
  logic [6:0] mag = 7'h00;
  logic [9:0] lp_d = 10'h000;
  logic [19:0] cmd_data = 20'h00000, rd_data, pen, pup;
  pfp_reg_t cmd_reg = PFP_REG_LEVEL, rd_reg = PFP_REG_LEVEL;
  logic [4:0] lin, lout, loe;
  int err_total = 0, checks = 0, n_rej = 0;
  pfp_pin_config #(.HOLD_UNIT_CYCLES(10)) i_dut (.clk(clk), .reset(reset),
    .cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
    .cmd_apply(cmd_apply), .cmd_reject(cmd_reject), .rd_reg(rd_reg),
    .rd_data(rd_data), .variant_through_hole(th), .asleep(asleep),
    .sleep_request_input(sri), .rx_packet(rx), .rx_power_mag(mag),
    .lp_source_valid(lp_src), .lp_sample_valid(lp_v),
    .lp_sample_data(lp_d), .spi_peripheral_dout(spi), .line_in(lin),
    .line_out(lout), .line_oe(loe), .dio_pull_enable(pen),
    .dio_pull_up(pup), .level_map(lmap));
  pfp_pads i_pads (.clk(clk), .line_out(lout), .line_oe(loe),
    .dio_pull_enable(pen), .dio_pull_up(pup), .line_in(lin));
  initial forever #10 clk = ~clk;
  // refusals are counted here since the pulse lasts a single cycle
  always @(posedge clk) if (cmd_reject === 1'b1) n_rej++;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input pfp_reg_t r, input logic [19:0] d);
    @(posedge clk) begin cmd_write <= 1; cmd_reg <= r; cmd_data <= d; end
    @(posedge clk) cmd_write <= 0;
  endtask
  task automatic rd(input pfp_reg_t r, input logic [19:0] m, e);
    @(posedge clk) rd_reg <= r;
    repeat (2) @(posedge clk);
    #1 chk(rd_data & m, e);
  endtask
  task automatic apply();
    @(posedge clk) cmd_apply <= 1;
    @(posedge clk) cmd_apply <= 0;
  endtask
  task automatic t_reset();
    rd(PFP_REG_SEL_SLEEP_RQ, 20'hfffff, 20'h00001);
    rd(PFP_REG_SEL_LINE10, 20'hfffff, 20'h00001);
    rd(PFP_REG_SEL_LINE11, 20'hfffff, 20'h00000);
    rd(PFP_REG_PULL_EN, 20'hfffff, 20'h0ffff);
    rd(PFP_REG_PULL_DIR, 20'hfffff, 20'h0ffff);
    rd(PFP_REG_HOLD, 20'hfffff, 20'h00028);
    // asleep: request line floats unpulled, indicator shows asleep
    @(posedge clk) asleep <= 1;
    repeat (3) @(posedge clk);
    #1 chk({loe[0], pen[8]}, 2'b00);
    chk({loe[1], lout[1]}, 2'b10);
  endtask
  task automatic t_reject();
    wr(PFP_REG_SEL_LINE11, 20'h00001);
    wr(PFP_REG_SEL_SLEEP_RQ, 20'h00002);
    wr(PFP_REG_SEL_LINE12, 20'h00001);
    repeat (3) @(posedge clk);
    chk(20'(n_rej), 20'h3);
    rd(PFP_REG_SEL_LINE11, 20'hfffff, 20'h00000);
    rd(PFP_REG_SEL_LINE12, 20'hfffff, 20'h00000);
    // through-hole strap: spi data out allowed, upper mask bits refused
    @(posedge clk) th <= 1;
    repeat (3) @(posedge clk);
    wr(PFP_REG_SEL_LINE12, 20'h00001);
    wr(PFP_REG_PULL_EN, 20'h10000);
    @(posedge clk) spi <= 1;
    repeat (3) @(posedge clk);
    #1 chk(20'(n_rej), 20'h4);
    chk({loe[4], lout[4]}, 2'b11);
    rd(PFP_REG_SEL_LINE12, 20'hfffff, 20'h00001);
    rd(PFP_REG_PULL_EN, 20'hfffff, 20'h0ffff);
  endtask
  task automatic t_lines();
    wr(PFP_REG_SEL_SLEEP_RQ, 20'h00005);
    wr(PFP_REG_SEL_LINE10, 20'h00005);
    repeat (3) @(posedge clk);
    #1 chk({loe[0], lout[0], sri}, 3'b110);
    chk({loe[2], lout[2]}, 2'b11);
    // drive low first so a missing pull-up cannot read back high
    wr(PFP_REG_SEL_LINE10, 20'h00004);
    wr(PFP_REG_SEL_LINE10, 20'h00003);
    repeat (3) @(posedge clk);
    rd(PFP_REG_STATUS, 20'h00004, 20'h00004);
    wr(PFP_REG_PULL_EN, 20'h01000);
    wr(PFP_REG_PULL_DIR, 20'h00000);
    repeat (3) @(posedge clk);
    #1 chk(pen[12:8], 5'h08);
    chk(pup[11], 1'b0);
    wr(PFP_REG_SEL_LINE11, 20'h00004);
    repeat (3) @(posedge clk);
    #1 chk({pen[11], loe[3], lout[3]}, 3'b010);
    wr(PFP_REG_LEVEL, 20'h000fa);
    repeat (3) @(posedge clk);
    #1 chk({loe[3], lout[3], loe[0], lout[0]}, 4'b1110);
    chk(lmap, 8'hfa);
  endtask
  task automatic t_pwm();
    int hi = 0;
    wr(PFP_REG_SEL_LINE10, 20'h00002);
    wr(PFP_REG_SEL_LINE11, 20'h00002);
    wr(PFP_REG_DUTY0, 20'h003ff);
    apply();
    lp_src <= 1;
    @(posedge clk) begin lp_v <= 1; lp_d <= 10'h3ff; end
    @(posedge clk) lp_v <= 0;
    repeat (3300) @(posedge clk);
    #1 chk(lout[3:2], 2'b11);
    rd(PFP_REG_DUTY1, 20'hfffff, 20'h003ff);
    // a staged duty must wait for apply
    wr(PFP_REG_DUTY0, 20'h00000);
    repeat (3300) @(posedge clk);
    #1 chk(lout[2], 1'b1);
    apply();
    repeat (3300) @(posedge clk);
    #1 chk(lout[3:2], 2'b10);
    // half duty: about 1598 high cycles in one 3200-cycle period
    wr(PFP_REG_DUTY0, 20'h001ff);
    apply();
    repeat (3300) @(posedge clk);
    repeat (3200) @(posedge clk) hi += lout[2];
    chk(20'(hi >= 1590 && hi <= 1610), 20'h1);
  endtask
  task automatic t_hold();
    int hi = 0;
    wr(PFP_REG_SEL_LINE10, 20'h00001);
    wr(PFP_REG_HOLD, 20'h00002);
    @(posedge clk) rx <= 1;
    @(posedge clk) rx <= 0;
    rd(PFP_REG_STATUS, 20'h00040, 20'h00040);
    repeat (30) @(posedge clk);
    rd(PFP_REG_STATUS, 20'h00040, 20'h00000);
    chk({loe[2], lout[2]}, 2'b10);
    wr(PFP_REG_HOLD, 20'h000ff);
    // magnitude 0x40 maps to duty 0x1ff, about half high
    @(posedge clk) begin rx <= 1; mag <= 7'h40; end
    @(posedge clk) rx <= 0;
    repeat (3300) @(posedge clk);
    repeat (3200) @(posedge clk) hi += lout[2];
    chk(20'(hi >= 1590 && hi <= 1610), 20'h1);
    rd(PFP_REG_STATUS, 20'h00040, 20'h00040);
  endtask
  task automatic finish_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the whole run is near 23000 cycles; the limit is 60000 cycles
  initial begin
    #1200000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    t_reset();
    t_reject();
    t_lines();
    t_pwm();
    t_hold();
    finish_test();
  end
endmodule
